// *** design/wsw_lf_tick.sv ***
// low-frequency oscillator model: one-cycle enable at the 31 kHz rate
// assumes the system clock on the clock line of the package
`timescale 1ns/100ps
module wsw_lf_tick
  import wsw_pkg::*;
#(
  parameter int TICK_CYCLES = WSW_LF_TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // enable pulse
  output logic tick
);

  localparam int CW = $clog2(TICK_CYCLES);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } wsw_tick_state_t;

  wsw_tick_state_t cur_reg, cur_next;

  always_comb begin
    cur_next = cur_reg;
    cur_next.tick = 1'b0;
    if (cur_reg.cnt == CW'(TICK_CYCLES - 1)) begin
      cur_next.cnt = '0;
      cur_next.tick = 1'b1;
    end else begin
      cur_next.cnt = cur_reg.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign tick = cur_reg.tick;

endmodule // wsw_lf_tick

// *** design/wsw_pkg.sv ***
// constants, types and register map of the watchdog with sleep and wake control
// assumes a single 50 MHz clock and an apb master holding requests until pready
package wsw_pkg;

  // ----------------------------------------------------------------
  // clock and time base
  // ----------------------------------------------------------------
  localparam int WSW_CLK_HZ = 50_000_000;
  localparam int WSW_LF_OSC_HZ = 31_000;
  localparam int WSW_LF_TICK_CYCLES = (WSW_CLK_HZ + WSW_LF_OSC_HZ - 1) / WSW_LF_OSC_HZ;
  localparam int WSW_OST_OSC_PERIODS = 1024;
  localparam int WSW_OST_CYCLES = WSW_OST_OSC_PERIODS * 1;
  localparam int WSW_OST_W = $clog2(WSW_OST_CYCLES);

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] WSW_ADDR_WDCTL = 8'h00;
  localparam logic [7:0] WSW_ADDR_OPTION = 8'h04;
  localparam logic [7:0] WSW_ADDR_STATUS = 8'h08;
  localparam logic [7:0] WSW_WDCTL_RESET = 8'h08;
  localparam logic [7:0] WSW_OPTION_RESET = 8'hFF;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int WSW_SOFT_EN_BIT = 0;
  localparam int WSW_PSEL_LSB = 1;
  localparam int WSW_PSEL_MSB = 4;
  localparam int WSW_OPT_PSA_BIT = 3;
  localparam int WSW_OPT_PS_LSB = 0;
  localparam int WSW_OPT_PS_MSB = 2;
  localparam logic [3:0] WSW_PSEL_MAX = 4'hB;
  localparam int WSW_WAKE_SRC_N = 8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    WSW_OSC_LP, WSW_OSC_XT, WSW_OSC_HS, WSW_OSC_EXTERNAL_CLOCK_INPUT,
    WSW_OSC_INTERNAL_OSCILLATOR, WSW_OSC_EXTERNAL_RC_CLOCK, WSW_OSC_TIMER
  } wsw_osc_mode_t;

  typedef enum logic [1:0] {WSW_ST_RUN, WSW_ST_SLEEP, WSW_ST_OST} wsw_state_t;

endpackage

// *** design/wsw_sync3.sv ***
// three-stage synchroniser for one pin input
// a new level is taken only once the second and third stages agree
`timescale 1ns/100ps
module wsw_sync3
  import wsw_pkg::*;
#(
  parameter logic RESET_VAL = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin and clean level
  input wire logic pin_in,
  output logic level_out
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } wsw_sync_state_t;

  wsw_sync_state_t cur_reg, cur_next;

  always_comb begin
    cur_next = cur_reg;
    cur_next.s1 = pin_in;
    cur_next.s2 = cur_reg.s1;
    cur_next.s3 = cur_reg.s2;
    if (cur_reg.s2 == cur_reg.s3) begin
      cur_next.lvl = cur_reg.s3;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_reg <= '{s1: RESET_VAL, s2: RESET_VAL, s3: RESET_VAL, lvl: RESET_VAL};
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign level_out = cur_reg.lvl;

endmodule // wsw_sync3

// *** design/wsw_watchdog_sleep_wake.sv ***
// watchdog timer with sleep entry, wake-up and reset status flags, apb slave
// assumes the core drives instruction pulses on clk and keeps them one cycle
//
// Function
// - time base comes only from the low-frequency oscillator; ready flag ignores it
// - 16-bit prescaler optionally chained with the shared 8-bit prescaler
// - every reset loads period 1:512 and soft enable zero
// - watchdog held cleared while the start-up timer counts
// - configuration enable runs the watchdog; soft enable then has no effect
// - with configuration enable low, soft enable bit 0 turns watchdog on or off
// - period field bits 4..1 doubles 1:32 to 1:65536; codes above 1011 reserved
// - bits 7..5 of watchdog control read as zero
// - count cleared when disabled, on clear instruction, osc failure, or sleep entry
// - crystal sleep exit keeps watchdog cleared until the 1024-period start-up ends
// - sleep clears watchdog, clears powerdown, sets timeout, stops osc, holds pins
// - watchdog reset never drives the master clear pin
// - master clear in sleep resets; watchdog or interrupt wake continues execution
// - powerdown set at power-up, cleared at sleep; timeout cleared on watchdog wake
// - interrupt wakes only with its own enable set, regardless of global enable
// - prefetch during sleep; after interrupt wake, vector only when global enable set
// - watchdog cleared on every wake from sleep
// - pending enabled interrupt turns sleep into a no-operation
// - interrupt during sleep completes sleep effects, then wakes at once
// - only clockless wake-capable interrupt sources can wake the device
`timescale 1ns/100ps
module wsw_watchdog_sleep_wake
  import wsw_pkg::*;
#(
  parameter int LF_TICK_CYCLES = WSW_LF_TICK_CYCLES,
  parameter int OST_CYCLES = WSW_OST_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // configuration and clock system
  input wire logic config_watchdog_enable,
  input wire logic [2:0] osc_mode,
  input wire logic sys_clk_on_lf_osc,
  input wire logic osc_fail_detect,
  // core events
  input wire logic clear_watchdog_instr,
  input wire logic sleep_instr,
  input wire logic global_int_enable,
  // wake-capable interrupt sources
  input wire logic [WSW_WAKE_SRC_N-1:0] wake_int_flags,
  input wire logic [WSW_WAKE_SRC_N-1:0] wake_int_enables,
  // pin
  input wire logic master_clear_pin_n,
  // resets and wake
  output logic watchdog_reset,
  output logic device_reset,
  output logic wake_pulse,
  output logic wake_int_vector,
  output logic prefetch_next,
  // sleep controls and status
  output logic osc_driver_off,
  output logic io_hold,
  output logic powerdown_flag_n,
  output logic timeout_flag_n,
  output logic lowfreq_ready_flag,
  output logic watchdog_running
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam int OW = $clog2(OST_CYCLES);

  typedef struct packed {
    wsw_state_t st;
    logic [15:0] base_cnt;
    logic [7:0] post_cnt;
    logic [OW-1:0] ost_cnt;
    logic [4:0] wdctl;
    logic [7:0] option;
    logic pd_n;
    logic to_n;
    logic master_clear_pin_q;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic wd_rst;
    logic dev_rst;
    logic wake;
    logic wake_vec;
    logic prefetch;
    logic asleep;
    logic lf_ready;
    logic running;
  } wsw_main_state_t;

  wsw_main_state_t cur_reg, cur_next;
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic lf_tick;
  logic master_clear_pin_lvl;

  // ----------------------------------------------------------------
  // reset release and helpers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  wsw_lf_tick #(
    .TICK_CYCLES(LF_TICK_CYCLES)
  ) u_lf_tick (
    .clk(clk),
    .rst_n(rst_n),
    .tick(lf_tick)
  );

  wsw_sync3 #(
    .RESET_VAL(1'b1)
  ) u_master_clear_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(master_clear_pin_n),
    .level_out(master_clear_pin_lvl)
  );

  function automatic logic [15:0] period_limit(input logic [3:0] sel);
    logic [3:0] code;
    code = (sel > WSW_PSEL_MAX) ? WSW_PSEL_MAX : sel;
    return 16'((17'h00020 << code) - 17'h00001);
  endfunction

  function automatic logic is_crystal(input logic [2:0] mode);
    return (mode == WSW_OSC_LP) || (mode == WSW_OSC_XT) || (mode == WSW_OSC_HS);
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic wd_en;
  logic int_pending;
  logic base_hit;
  logic post_hit;
  logic timeout;
  logic wd_clear;
  logic apb_done;
  logic master_clear_pin_fall;
  logic [7:0] post_lim;
  logic [31:0] rd_val;
  logic rd_err;

  always_comb begin
    cur_next = cur_reg;
    cur_next.wd_rst = 1'b0;
    cur_next.dev_rst = 1'b0;
    cur_next.wake = 1'b0;
    cur_next.wake_vec = 1'b0;
    cur_next.prefetch = 1'b0;
    cur_next.master_clear_pin_q = master_clear_pin_lvl;
    wd_en = config_watchdog_enable | cur_reg.wdctl[WSW_SOFT_EN_BIT];
    int_pending = |(wake_int_flags & wake_int_enables);
    post_lim = 8'((9'h001 << cur_reg.option[WSW_OPT_PS_MSB:WSW_OPT_PS_LSB]) - 9'h001);
    base_hit = lf_tick && (cur_reg.base_cnt == period_limit(cur_reg.wdctl[4:1]));
    post_hit = !cur_reg.option[WSW_OPT_PSA_BIT] || (cur_reg.post_cnt == post_lim);
    timeout = wd_en && (cur_reg.st != WSW_ST_OST) && base_hit && post_hit;
    wd_clear = !wd_en || clear_watchdog_instr || osc_fail_detect;
    master_clear_pin_fall = cur_reg.master_clear_pin_q && !master_clear_pin_lvl;
    apb_done = psel && penable && cur_reg.pready;
    cur_next.lf_ready = sys_clk_on_lf_osc;

    // register reads
    rd_err = 1'b0;
    unique case (paddr)
      WSW_ADDR_WDCTL: rd_val = {24'h000000, 3'b000, cur_reg.wdctl};
      WSW_ADDR_OPTION: rd_val = {24'h000000, cur_reg.option};
      WSW_ADDR_STATUS: rd_val = {28'h0000000, cur_reg.running, cur_reg.asleep,
                                 cur_reg.to_n, cur_reg.pd_n};
      default: begin
        rd_val = 32'h00000000;
        rd_err = 1'b1;
      end
    endcase

    // apb: one wait state, write lands on the completing edge
    cur_next.pready = 1'b0;
    if (psel && penable && !cur_reg.pready) begin
      cur_next.pready = 1'b1;
      cur_next.pslverr = rd_err;
      cur_next.prdata = pwrite ? 32'h00000000 : rd_val;
    end
    if (apb_done && pwrite && !rd_err) begin
      unique case (paddr)
        WSW_ADDR_WDCTL: cur_next.wdctl = pwdata[4:0];
        WSW_ADDR_OPTION: cur_next.option = pwdata[7:0];
        default: begin
        end
      endcase
    end

    // watchdog count
    if (lf_tick && wd_en && (cur_reg.st != WSW_ST_OST)) begin
      if (base_hit) begin
        cur_next.base_cnt = 16'h0000;
        if (cur_reg.option[WSW_OPT_PSA_BIT] && !post_hit) begin
          cur_next.post_cnt = cur_reg.post_cnt + 8'h01;
        end
      end else begin
        cur_next.base_cnt = cur_reg.base_cnt + 16'h0001;
      end
    end

    // sequencing
    unique case (cur_reg.st)
      WSW_ST_RUN: begin
        if (timeout) begin
          cur_next.wd_rst = 1'b1;
          cur_next.to_n = 1'b0;
          cur_next.wdctl = WSW_WDCTL_RESET[4:0];
          cur_next.option = WSW_OPTION_RESET;
          wd_clear = 1'b1;
        end else if (sleep_instr && !int_pending) begin
          cur_next.st = WSW_ST_SLEEP;
          cur_next.pd_n = 1'b0;
          cur_next.to_n = 1'b1;
          cur_next.asleep = 1'b1;
          cur_next.prefetch = 1'b1;
          wd_clear = 1'b1;
        end else if (sleep_instr) begin
          cur_next.prefetch = 1'b1;
        end
      end
      WSW_ST_SLEEP: begin
        if (timeout || int_pending) begin
          cur_next.wake = 1'b1;
          cur_next.wake_vec = !timeout && global_int_enable;
          cur_next.asleep = 1'b0;
          cur_next.to_n = !timeout;
          wd_clear = 1'b1;
          if (is_crystal(osc_mode)) begin
            cur_next.st = WSW_ST_OST;
            cur_next.ost_cnt = '0;
          end else begin
            cur_next.st = WSW_ST_RUN;
          end
        end
      end
      WSW_ST_OST: begin
        wd_clear = 1'b1;
        if (!is_crystal(osc_mode) || (cur_reg.ost_cnt == OW'(OST_CYCLES - 1))) begin
          cur_next.st = WSW_ST_RUN;
        end else begin
          cur_next.ost_cnt = cur_reg.ost_cnt + OW'(1);
        end
      end
      default: begin
        cur_next.st = WSW_ST_RUN;
      end
    endcase

    // master clear pin: full device reset, also out of sleep
    if (master_clear_pin_fall) begin
      cur_next.dev_rst = 1'b1;
      cur_next.wake = 1'b0;
      cur_next.wake_vec = 1'b0;
      cur_next.wd_rst = 1'b0;
      cur_next.wdctl = WSW_WDCTL_RESET[4:0];
      cur_next.option = WSW_OPTION_RESET;
      cur_next.asleep = 1'b0;
      if (cur_reg.st == WSW_ST_SLEEP) begin
        cur_next.to_n = 1'b1;
        cur_next.pd_n = 1'b0;
      end
      cur_next.st = is_crystal(osc_mode) ? WSW_ST_OST : WSW_ST_RUN;
      cur_next.ost_cnt = '0;
      wd_clear = 1'b1;
    end

    if (wd_clear) begin
      cur_next.base_cnt = 16'h0000;
      cur_next.post_cnt = 8'h00;
    end
    cur_next.running = wd_en && (cur_next.st != WSW_ST_OST);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_reg <= '0;
      cur_reg.st <= WSW_ST_OST;
      cur_reg.wdctl <= WSW_WDCTL_RESET[4:0];
      cur_reg.option <= WSW_OPTION_RESET;
      cur_reg.pd_n <= 1'b1;
      cur_reg.to_n <= 1'b1;
      cur_reg.master_clear_pin_q <= 1'b1;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = cur_reg.prdata;
  assign pready = cur_reg.pready;
  assign pslverr = cur_reg.pslverr;
  assign watchdog_reset = cur_reg.wd_rst;
  assign device_reset = cur_reg.dev_rst;
  assign wake_pulse = cur_reg.wake;
  assign wake_int_vector = cur_reg.wake_vec;
  assign prefetch_next = cur_reg.prefetch;
  assign osc_driver_off = cur_reg.asleep;
  assign io_hold = cur_reg.asleep;
  assign powerdown_flag_n = cur_reg.pd_n;
  assign timeout_flag_n = cur_reg.to_n;
  assign lowfreq_ready_flag = cur_reg.lf_ready;
  assign watchdog_running = cur_reg.running;

endmodule // wsw_watchdog_sleep_wake

// *** tb/tb_top.sv ***
// testbench: apb register checks, timeouts, sleep entry and wake-up
// assumes the block with short tick and start-up counts of 4 and 8
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
  $display("Error %0t: got %h exp %h", $time, a, e); end end
`define WT(s, n) begin repeat (n) if ((s) !== 1'b1) @(posedge clk); `CHK(s, 1'b1) end
module tb_top;
  import wsw_pkg::*;
  // ----------------------------------------------------------------
  // signals and design
  // ----------------------------------------------------------------
  logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0, wake_int_flags = 0, wake_int_enables = 0, b;
  logic [31:0] pwdata = 0, prdata, v, rs = 32'hA46FB463;
  logic [2:0] osc_mode = 3'h4;
  logic pready, pslverr, config_watchdog_enable = 0, sys_clk_on_lf_osc = 0;
  logic osc_fail_detect = 0, clear_watchdog_instr = 0, sleep_instr = 0;
  logic global_int_enable = 0, master_clear_pin_n = 1;
  logic watchdog_reset, device_reset, wake_pulse, wake_int_vector, prefetch_next;
  logic osc_driver_off, io_hold, powerdown_flag_n, timeout_flag_n;
  logic lowfreq_ready_flag, watchdog_running;
  logic [32:0] expq[$];
  logic [32:0] xq;
  int err_total = 0, cmp_count = 0, cyc = 0, nwr = 0, n, e;
  wsw_watchdog_sleep_wake #(.LF_TICK_CYCLES(4), .OST_CYCLES(8)) wsw_watchdog_sleep_wake_i (.*);
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    if (++cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
    nwr <= nwr + (watchdog_reset === 1'b1);
    sys_clk_on_lf_osc <= cyc > 14 && cyc[2];
    if (pready === 1'b1 && pwrite === 1'b0) begin
      xq = expq.pop_front();
      `CHK({pslverr, prdata}, xq)
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] x);
    if (!w) expq.push_back(x);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
    @(posedge clk);
  endtask
  task automatic ev(input logic [2:0] s);
    {osc_fail_detect, clear_watchdog_instr, sleep_instr} <= s;
    @(posedge clk) {osc_fail_detect, clear_watchdog_instr, sleep_instr} <= 3'b000;
    @(posedge clk);
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d, compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1;
    repeat (4) @(posedge clk);
    apb(0, WSW_ADDR_WDCTL, 0, 33'h08);
    apb(0, WSW_ADDR_OPTION, 0, 33'hFF);
    apb(0, WSW_ADDR_STATUS, 0, 33'h03);
    apb(0, 8'h0C, 0, {1'b1, 32'h0});
    {wake_int_flags, wake_int_enables} <= 16'h8080;
    ev(3'b001);
    wake_int_flags <= 0;
    apb(0, WSW_ADDR_STATUS, 0, 33'h03);
    v = rnd();
    apb(1, WSW_ADDR_WDCTL, v | 32'hE0, 0);
    apb(0, WSW_ADDR_WDCTL, 0, {1'b0, v & 32'h1F});
    for (int i = 0; i < 3; i++) begin
      config_watchdog_enable <= i == 2;
      apb(1, WSW_ADDR_OPTION, i == 1 ? 32'h09 : 32'h00, 0);
      apb(1, WSW_ADDR_WDCTL, i != 2, 0);
      for (int k = 0; k < 8; k++) begin
        repeat (40) @(posedge clk);
        ev(k[0] ? 3'b100 : 3'b010);
      end
      `CHK(nwr, i)
      e = i == 1 ? 256 : 128;
      n = 0;
      while (watchdog_reset !== 1'b1 && n < 400) begin
        @(posedge clk);
        n++;
      end
      `CHK(n >= e - 8 && n <= e + 8, 1'b1)
      apb(0, WSW_ADDR_WDCTL, 0, 33'h08);
      apb(0, WSW_ADDR_STATUS, 0, {32'h01, 1'b1} >> 1 | (i == 2) << 3);
    end
    config_watchdog_enable <= 0;
    apb(1, WSW_ADDR_OPTION, 0, 0);
    apb(1, WSW_ADDR_WDCTL, 32'h01, 0);
    ev(3'b010);
    ev(3'b001);
    apb(0, WSW_ADDR_STATUS, 0, 33'h0E);
    `WT(wake_pulse, 400)
    `CHK(wake_int_vector, 1'b0)
    apb(0, WSW_ADDR_STATUS, 0, 33'h08);
    config_watchdog_enable <= 1;
    apb(1, WSW_ADDR_WDCTL, 32'h16, 0);
    for (int i = 0; i < 4; i++) begin
      {global_int_enable, osc_mode} <= {i[0], i[1] ? 3'h1 : 3'h4};
      b = 8'h01 << (rnd() & 7);
      {wake_int_flags, wake_int_enables} <= {b, 8'h00};
      ev(3'b001);
      repeat (20) @(posedge clk);
      `CHK(osc_driver_off, 1'b1)
      wake_int_enables <= b;
      `WT(wake_pulse, 20)
      `CHK(wake_int_vector, i[0])
      apb(0, WSW_ADDR_STATUS, 0, {29'h0, !i[1], 3'b010});
      {wake_int_flags, wake_int_enables} <= 16'h0;
      repeat (8) @(posedge clk);
    end
    osc_mode <= 3'h4;
    ev(3'b001);
    master_clear_pin_n <= 0;
    `WT(device_reset, 20)
    master_clear_pin_n <= 1;
    repeat (4) @(posedge clk);
    apb(0, WSW_ADDR_STATUS, 0, 33'h0A);
    @(posedge clk);
    tally_and_finish();
  end
endmodule // tb_top

// *** tb/wsw_chk.sv ***
// checker: concurrent assertions on the watchdog sleep wake ports
// assumes one clock domain; bound to the top module below
`timescale 1ns/100ps
module wsw_chk (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // watched inputs
  input wire logic sleep_instr,
  input wire logic sys_clk_on_lf_osc,
  input wire logic [7:0] wake_int_flags,
  input wire logic [7:0] wake_int_enables,
  // watched outputs
  input wire logic watchdog_reset,
  input wire logic device_reset,
  input wire logic wake_pulse,
  input wire logic wake_int_vector,
  input wire logic prefetch_next,
  input wire logic osc_driver_off,
  input wire logic io_hold,
  input wire logic powerdown_flag_n,
  input wire logic timeout_flag_n,
  input wire logic lowfreq_ready_flag,
  input wire logic watchdog_running
);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic pend;
  assign pend = |(wake_int_flags & wake_int_enables);
  sleep_entry_a: assert property (sleep_instr && !osc_driver_off && !pend |=>
    osc_driver_off && io_hold && !powerdown_flag_n && timeout_flag_n) else $error("bad sleep");
  sleep_noop_a: assert property (sleep_instr && !osc_driver_off && pend |=>
    !osc_driver_off && $stable(powerdown_flag_n) && $stable(timeout_flag_n)) else $error("no-op");
  int_wake_a: assert property (osc_driver_off && pend |=> wake_pulse)
    else $error("no wake");
  wake_release_a: assert property (wake_pulse |-> !osc_driver_off && !io_hold)
    else $error("still asleep");
  wake_vector_a: assert property (wake_int_vector |-> wake_pulse && timeout_flag_n)
    else $error("bad vector");
  wd_reset_a: assert property (watchdog_reset |->
    !timeout_flag_n && $past(watchdog_running) && !$past(osc_driver_off)) else $error("reset");
  prefetch_a: assert property (sleep_instr && !osc_driver_off |=> prefetch_next)
    else $error("no prefetch");
  lf_ready_a: assert property (1'b1 |=> lowfreq_ready_flag == $past(sys_clk_on_lf_osc))
    else $error("ready flag");
  cover property (sleep_instr && !pend ##1 osc_driver_off);
  cover property (watchdog_reset);
  cover property (wake_int_vector);
  cover property (device_reset && !powerdown_flag_n);
endmodule // wsw_chk

bind wsw_watchdog_sleep_wake wsw_chk wsw_chk_i (.clk, .arst_n, .sleep_instr,
  .sys_clk_on_lf_osc, .wake_int_flags, .wake_int_enables, .watchdog_reset, .device_reset,
  .wake_pulse, .wake_int_vector, .prefetch_next, .osc_driver_off, .io_hold,
  .powerdown_flag_n, .timeout_flag_n, .lowfreq_ready_flag, .watchdog_running);
